// ### src/isteph_engine.sv
/*
  Byte-step two-wire master engine with completion flag handshake.
  Assumes open-drain pins resolved outside; bus inputs are asynchronous.
*/
`timescale 1ns/1ps
module isteph_engine #(
  parameter int QTR = isteph_pkg::QTR_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [1:0] scl_s_r, sda_s_r;
  logic scl_d_r, sda_d_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end
  wire scl_q = scl_s_r[1];
  wire sda_q = sda_s_r[1];
  wire start_seen = scl_q && scl_d_r && sda_d_r && !sda_q;
  wire stop_seen = scl_q && scl_d_r && !sda_d_r && sda_q;

  // Bus busy tracker for other masters
  logic busy_r;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) busy_r <= 1'b0;
    else if (stop_seen) busy_r <= 1'b0;
    else if (start_seen) busy_r <= 1'b1;
  end

  // ****************************************
  // Registers
  // ****************************************
  logic flag_r, sta_r, sto_r, wc_r, en_r, ie_r, gie_r;
  logic [1:0] ps_r;
  logic [4:0] code_r;
  logic [7:0] data_r;
  logic set_flag;
  isteph_pkg::isteph_state_t st_r;

  wire ctrl_wr = wr && addr == isteph_pkg::ADDR_CTRL;
  wire launch = ctrl_wr && wdata[isteph_pkg::BIT_FLAG] && flag_r; // RULE_04
  wire kick = ctrl_wr && wdata[isteph_pkg::BIT_FLAG] && wdata[isteph_pkg::BIT_EN];

  // Set wins over a simultaneous clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) flag_r <= 1'b0; // RULE_22
    else if (set_flag) flag_r <= 1'b1; // RULE_01
    else if (ctrl_wr && wdata[isteph_pkg::BIT_FLAG]) flag_r <= 1'b0; // RULE_04
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sta_r <= 1'b0;
      en_r <= 1'b0;
      ie_r <= 1'b0;
    end else if (ctrl_wr) begin
      sta_r <= wdata[isteph_pkg::BIT_STA];
      en_r <= wdata[isteph_pkg::BIT_EN];
      ie_r <= wdata[isteph_pkg::BIT_IE];
    end
  end

  logic sto_done;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) sto_r <= 1'b0;
    else if (sto_done) sto_r <= 1'b0; // RULE_19
    else if (ctrl_wr) sto_r <= wdata[isteph_pkg::BIT_STO];
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ps_r <= 2'h0;
      gie_r <= 1'b0;
    end else begin
      if (wr && addr == isteph_pkg::ADDR_STAT) ps_r <= wdata[1:0];
      if (wr && addr == isteph_pkg::ADDR_GLOB) gie_r <= wdata[0];
    end
  end

  assign irq = flag_r && ie_r && gie_r; // RULE_02

  // ****************************************
  // Bit timing and sequencer
  // ****************************************
  logic [$clog2(QTR+1)-1:0] tick_cnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_r, rnw_r, is_addr_r, scl_o_r, sda_o_r;
  wire tick = tick_cnt_r == ($clog2(QTR+1))'(QTR - 1);
  wire run = st_r == isteph_pkg::ISTEP_START || st_r == isteph_pkg::ISTEP_BYTE
    || st_r == isteph_pkg::ISTEP_STOP;
  // A slave may stretch the clock: the high phase only counts once the line is seen high
  wire stall = ph_r == 2'h2 && scl_o_r && !scl_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) tick_cnt_r <= '0;
    else if (!run || tick || stall) tick_cnt_r <= '0;
    else tick_cnt_r <= tick_cnt_r + 1'b1;
  end

  assign set_flag = run && tick && ph_r == 2'h3
    && ((st_r == isteph_pkg::ISTEP_START) || (st_r == isteph_pkg::ISTEP_BYTE && bit_r == 4'h8));
  assign sto_done = st_r == isteph_pkg::ISTEP_STOP && tick && ph_r == 2'h3;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r <= isteph_pkg::ISTEP_IDLE; // RULE_22
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h0;
      ack_r <= 1'b1;
      rnw_r <= 1'b0;
      is_addr_r <= 1'b0;
      scl_o_r <= 1'b1;
      sda_o_r <= 1'b1;
    end else begin
      case (st_r)
        isteph_pkg::ISTEP_IDLE, isteph_pkg::ISTEP_HOLD: begin
          if (!en_r) begin
            st_r <= isteph_pkg::ISTEP_IDLE;
            scl_o_r <= 1'b1;
            sda_o_r <= 1'b1;
          end
          // Only a flag-clearing write launches anything
          if ((launch || (kick && st_r == isteph_pkg::ISTEP_IDLE)) && !set_flag) begin // RULE_05
            ph_r <= 2'h0;
            if (wdata[isteph_pkg::BIT_STA]) begin // RULE_13
              st_r <= (busy_r && st_r == isteph_pkg::ISTEP_IDLE) ?
                isteph_pkg::ISTEP_WAITBUS : isteph_pkg::ISTEP_START; // RULE_06
            end else if (wdata[isteph_pkg::BIT_STO]) begin
              st_r <= isteph_pkg::ISTEP_STOP;
            end else if (st_r == isteph_pkg::ISTEP_HOLD) begin
              st_r <= isteph_pkg::ISTEP_BYTE; // RULE_08
              sh_r <= data_r;
              bit_r <= 4'h0;
            end
          end
        end
        isteph_pkg::ISTEP_WAITBUS: begin
          if (stop_seen || !busy_r) st_r <= isteph_pkg::ISTEP_START; // RULE_20
        end
        isteph_pkg::ISTEP_START: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: begin
              sda_o_r <= 1'b1;
              scl_o_r <= 1'b1;
            end
            2'h1: sda_o_r <= 1'b0;
            2'h2: scl_o_r <= 1'b0;
            default: begin
              st_r <= isteph_pkg::ISTEP_HOLD;
              is_addr_r <= 1'b1;
            end
          endcase
        end
        isteph_pkg::ISTEP_BYTE: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_o_r <= (bit_r == 4'h8) ? 1'b1 : sh_r[7];
            2'h1: scl_o_r <= 1'b1;
            2'h2: begin
              if (bit_r == 4'h8) ack_r <= sda_q;
              else sh_r <= {sh_r[6:0], sda_q};
            end
            default: begin
              scl_o_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                st_r <= isteph_pkg::ISTEP_HOLD;
                is_addr_r <= 1'b0;
                if (is_addr_r) rnw_r <= data_r[0];
              end
            end
          endcase
        end
        isteph_pkg::ISTEP_STOP: if (tick) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_o_r <= 1'b0;
            2'h1: scl_o_r <= 1'b1;
            2'h2: sda_o_r <= 1'b1;
            default: st_r <= isteph_pkg::ISTEP_IDLE; // RULE_11
          endcase
        end
        default: st_r <= isteph_pkg::ISTEP_IDLE;
      endcase
    end
  end

  // Status code follows the completed step
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) code_r <= isteph_pkg::ST_IDLE;
    else if (set_flag) begin // RULE_03
      if (st_r == isteph_pkg::ISTEP_START) code_r <= isteph_pkg::ST_START; // RULE_07
      else if (is_addr_r) begin
        if (data_r[0]) code_r <= ack_r ? isteph_pkg::ST_AR_NACK : isteph_pkg::ST_AR_ACK;
        else code_r <= ack_r ? isteph_pkg::ST_AW_NACK : isteph_pkg::ST_AW_ACK; // RULE_09
      end else begin
        code_r <= ack_r ? isteph_pkg::ST_DW_NACK : isteph_pkg::ST_DW_ACK; // RULE_10
      end
    end else if (!flag_r && st_r == isteph_pkg::ISTEP_IDLE) begin
      code_r <= isteph_pkg::ST_IDLE;
    end
  end

  // Received byte lands in the data register at the end of a byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) data_r <= isteph_pkg::DATA_RST;
    else if (set_flag && st_r == isteph_pkg::ISTEP_BYTE) data_r <= sh_r;
    else if (wr && addr == isteph_pkg::ADDR_DATA && flag_r) data_r <= wdata; // RULE_08
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) wc_r <= 1'b0;
    else if (wr && addr == isteph_pkg::ADDR_DATA) wc_r <= !flag_r; // RULE_21
  end

  // Open drain: drive only lows; hold clock low while the flag waits
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = en_r && (!scl_o_r || flag_r); // RULE_12
  assign sda_oe = en_r && !sda_o_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) rdata <= 8'h00;
    else if (rd) begin
      case (addr)
        isteph_pkg::ADDR_CTRL: rdata <= {flag_r, 1'b0, sta_r, sto_r, wc_r, en_r, 1'b0, ie_r};
        isteph_pkg::ADDR_STAT: rdata <= {code_r, 1'b0, ps_r}; // RULE_18
        isteph_pkg::ADDR_DATA: rdata <= data_r;
        default: rdata <= {7'h00, gie_r};
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_flag_holds_scl: assert property (@(posedge clock) disable iff (!nrst) // RULE_12
    flag_r && en_r |-> scl_oe) else $error("clock line released while flag set");
  a_no_start_flag: assert property (@(posedge clock) disable iff (!nrst) // RULE_05
    flag_r && !(ctrl_wr && wdata[isteph_pkg::BIT_FLAG]) |=> !(st_r inside
    {isteph_pkg::ISTEP_START, isteph_pkg::ISTEP_BYTE, isteph_pkg::ISTEP_STOP}))
    else $error("operation began with flag set");
  a_irq_gate: assert property (@(posedge clock) disable iff (!nrst) // RULE_02
    irq == (flag_r && ie_r && gie_r)) else $error("interrupt gating wrong");
  a_start_code: assert property (@(posedge clock) disable iff (!nrst) // RULE_07
    set_flag && st_r == isteph_pkg::ISTEP_START |=> flag_r && code_r == isteph_pkg::ST_START)
    else $error("start status missing");
  a_stop_noflag: assert property (@(posedge clock) disable iff (!nrst) // RULE_11
    sto_done |=> !$rose(flag_r)) else $error("flag set after stop");
  a_stop_clear: assert property (@(posedge clock) disable iff (!nrst) // RULE_19
    sto_done |=> !sto_r) else $error("stop bit not cleared");
  a_clear_one: assert property (@(posedge clock) disable iff (!nrst) // RULE_04
    flag_r && ctrl_wr && !wdata[isteph_pkg::BIT_FLAG] && !set_flag |=> flag_r)
    else $error("flag cleared by zero write");
  a_collision: assert property (@(posedge clock) disable iff (!nrst) // RULE_21
    wr && addr == isteph_pkg::ADDR_DATA && !flag_r |=> wc_r) else $error("collision not set");
  a_start_go: assert property (@(posedge clock) disable iff (!nrst) // RULE_06
    launch && wdata[isteph_pkg::BIT_STA] && !set_flag |=> st_r == isteph_pkg::ISTEP_START)
    else $error("start not begun");
endmodule

// ### src/isteph_pkg.sv
/*
  Constants for the two-wire step handshake engine: register offsets, field positions,
  reset values, status codes and bus timing.
  Assumes a 40 MHz system clock and a plain address/strobe register port.
*/
// Behaviour
// RULE_01: Flag rises after every START and every byte, then waits.
// RULE_02: Interrupt only when local and global enables set.
// RULE_03: Status holds code whenever flag is set.
// RULE_04: Writing one to flag bit clears it.
// RULE_05: No new operation while flag is set.
// RULE_06: Clearing flag with start bit starts START.
// RULE_07: After START, flag set, START code loaded.
// RULE_08: One data register serves address and data.
// RULE_09: Address sent: flag set, code shows acknowledge.
// RULE_10: Data sent: flag set, code shows acknowledge.
// RULE_11: No flag after STOP condition.
// RULE_12: Clock line held low while flag set.
// RULE_13: Same write selects START, transfer or STOP.
// RULE_14: Software loads registers before control write.
// RULE_15: Launching writes must carry flag bit one.
// RULE_16: Software checks status after each step.
// RULE_17: Single write: START, address, data, STOP.
// RULE_18: Status code bits 7..3, prescaler bits 1..0.
// RULE_19: Stop bit self-clears after STOP executed.
// RULE_20: START on busy bus waits for STOP.
// RULE_21: Data write while flag low sets collision.
// RULE_22: Reset: flag clear, lines released, idle.
package isteph_pkg;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_STAT = 2'h1;
  localparam logic [1:0] ADDR_DATA = 2'h2;
  localparam logic [1:0] ADDR_GLOB = 2'h3;
  localparam int BIT_FLAG = 7;
  localparam int BIT_STA = 5;
  localparam int BIT_STO = 4;
  localparam int BIT_WC = 3;
  localparam int BIT_EN = 2;
  localparam int BIT_IE = 0;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [4:0] ST_IDLE = 5'h1f;
  localparam logic [4:0] ST_START = 5'h01;
  localparam logic [4:0] ST_AW_ACK = 5'h03;
  localparam logic [4:0] ST_AW_NACK = 5'h04;
  localparam logic [4:0] ST_AR_ACK = 5'h08;
  localparam logic [4:0] ST_AR_NACK = 5'h09;
  localparam logic [4:0] ST_DW_ACK = 5'h05;
  localparam logic [4:0] ST_DW_NACK = 5'h06;
  localparam int SYS_CLK_HZ = 40000000;
  localparam int BUS_HZ = 100000;
  localparam int QTR_CYC = SYS_CLK_HZ / (4 * BUS_HZ);
  typedef enum logic [2:0] {
    ISTEP_IDLE = 3'b000,
    ISTEP_WAITBUS = 3'b001,
    ISTEP_START = 3'b010,
    ISTEP_BYTE = 3'b011,
    ISTEP_STOP = 3'b100,
    ISTEP_HOLD = 3'b101
  } isteph_state_t;
endpackage

// ### testbench/isteph_slave.sv
/*
  Behavioural slave on the two-wire bus: takes bytes, acknowledges or refuses them,
  and can stretch the clock. Assumes resolved open-drain levels with pull-ups.
*/
`timescale 1ns/1ps
module isteph_slave (
  input wire logic scl,
  input wire logic sda,
  input wire logic nack,
  input wire logic slow,
  output logic sda_oe,
  output logic scl_oe,
  output logic [7:0] got,
  output int starts,
  output int stops
);
  int bits = 0;
  logic busy = 1'b0;
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    got = 8'h00;
    starts = 0;
    stops = 0;
  end
  always @(negedge sda) if (scl) begin
    busy = 1'b1;
    bits = 0;
    starts++;
  end
  always @(posedge sda) if (scl && busy) begin
    busy = 1'b0;
    stops++;
  end
  always @(posedge scl) if (busy && bits < 8) begin
    got = {got[6:0], sda};
    bits++;
  end
  // Acknowledge changes on the falling edge only, never while the clock is high
  always @(negedge scl) if (busy) begin
    if (bits == 8) begin
      sda_oe = ~nack;
      bits = 9;
    end else if (bits == 9) begin
      sda_oe = 1'b0;
      bits = 0;
    end
    if (slow) begin
      scl_oe = 1'b1;
      #500 scl_oe = 1'b0;
    end
  end
endmodule

// ### testbench/isteph_engine_tb.sv
/*
  Self-checking bench for the step handshake engine: register port driver and checks.
  Assumes the package, the engine and the slave model are compiled before it.
*/
`timescale 1ns/1ps
module isteph_engine_tb;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] ctrl;
    logic [4:0] code;
    logic nack;
    logic slow;
  } isteph_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic nack = 1'b0;
  logic slow = 1'b0;
  logic [7:0] rdata, rv, got;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, irq;
  int starts, stops;
  int miscompares = 0;
  int check_count = 0;
  // Pull-ups on both lines
  wire scl = ~(scl_oe | m_scl_oe);
  wire sda = ~(sda_oe | m_sda_oe);
  localparam isteph_row_t ROWS [11] = '{
    '{8'h00, 8'ha4, isteph_pkg::ST_START, 1'b0, 1'b0},
    '{8'ha0, 8'h84, isteph_pkg::ST_AW_ACK, 1'b0, 1'b0},
    '{8'h5a, 8'h84, isteph_pkg::ST_DW_ACK, 1'b0, 1'b1},
    '{8'h00, 8'h94, 5'h00, 1'b0, 1'b0},
    '{8'h00, 8'ha4, isteph_pkg::ST_START, 1'b0, 1'b0},
    '{8'ha1, 8'h84, isteph_pkg::ST_AR_ACK, 1'b0, 1'b0},
    '{8'h00, 8'h94, 5'h00, 1'b0, 1'b0},
    '{8'h00, 8'ha4, isteph_pkg::ST_START, 1'b0, 1'b0},
    '{8'ha0, 8'h84, isteph_pkg::ST_AW_NACK, 1'b1, 1'b0},
    '{8'hc3, 8'h84, isteph_pkg::ST_DW_NACK, 1'b1, 1'b0},
    '{8'h00, 8'h94, 5'h00, 1'b0, 1'b0}
  };
  isteph_engine #(.QTR(4)) DUT (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq));
  isteph_slave slave (.scl(scl), .sda(sda), .nack(nack), .slow(slow), .sda_oe(m_sda_oe),
    .scl_oe(m_scl_oe), .got(got), .starts(starts), .stops(stops));
  always #12.5 clock = ~clock;
  // ****************************************
  // Register port tasks
  // ****************************************
  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  task automatic wait_ctrl(input int b, input logic v);
    int n;
    n = 0;
    rd_reg(2'h0);
    while (rv[b] !== v && n < 1000) begin
      rd_reg(2'h0);
      n++;
    end
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (50000) @(posedge clock);
    miscompares++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      nack <= ROWS[i].nack;
      slow <= ROWS[i].slow;
      if (ROWS[i].ctrl == 8'h84) wr_reg(2'h2, ROWS[i].data);
      wr_reg(2'h0, ROWS[i].ctrl);
      if (ROWS[i].ctrl != 8'h94) begin
        wait_ctrl(7, 1'b1);
        chk("flag", 8'h80, rv & 8'h80);
        repeat (20) @(posedge clock);
        chk("clock held low", 8'h01, {7'h00, scl_oe});
        rd_reg(2'h1);
        chk("status", {ROWS[i].code, 3'h0}, rv);
        if (ROWS[i].ctrl == 8'h84) chk("byte on bus", ROWS[i].data, got);
      end else begin
        wait_ctrl(4, 1'b0);
        chk("flag and stop bit", 8'h00, rv & 8'h90);
      end
    end
    chk("starts", 8'h03, starts[7:0]);
    chk("stops", 8'h03, stops[7:0]);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    chk("lines in reset", 8'h00, {6'h00, scl_oe, sda_oe});
    nrst <= 1'b1;
    rd_reg(2'h0);
    chk("ctrl reset", 8'h00, rv);
    rd_reg(2'h1);
    chk("status reset", {isteph_pkg::ST_IDLE, 3'h0}, rv);
    wr_reg(2'h2, 8'h11);
    rd_reg(2'h2);
    chk("data kept", isteph_pkg::DATA_RST, rv);
    rd_reg(2'h0);
    chk("collision set", 8'h08, rv & 8'h08);
    wr_reg(2'h0, 8'h24);
    repeat (200) @(posedge clock);
    chk("no launch", 8'h03, starts[7:0]);
    wr_reg(2'h0, 8'ha5);
    wait_ctrl(7, 1'b1);
    chk("irq global off", 8'h00, {7'h00, irq});
    wr_reg(2'h3, 8'h01);
    #1;
    chk("irq on", 8'h01, {7'h00, irq});
    wr_reg(2'h0, 8'h14);
    repeat (200) @(posedge clock);
    chk("irq local off", 8'h00, {7'h00, irq});
    chk("no stop while flag", 8'h03, stops[7:0]);
    rd_reg(2'h0);
    chk("flag kept", 8'h80, rv & 8'h80);
    wr_reg(2'h2, 8'h3c);
    rd_reg(2'h0);
    chk("collision cleared", 8'h00, rv & 8'h08);
    wr_reg(2'h1, 8'hff);
    rd_reg(2'h1);
    chk("prescaler", {isteph_pkg::ST_START, 3'h3}, rv);
    wr_reg(2'h0, 8'h94);
    wait_ctrl(4, 1'b0);
    chk("final stop", 8'h04, stops[7:0]);
    stop_test();
  end
endmodule
